// ===== hdl/sensor_batching_fifo_control.sv
// control and batching logic of the sensor sample fifo
//
// Operation
// - buffer holds 512 words: one tag byte then six data bytes
// - every write is paced by the faster main sensor's data-ready
// - 9-bit watermark: low byte in first register, msb in second bit 0
// - watermark flag high while stored count is at or above watermark
// - stop-at-watermark limits usable depth to the watermark level
// - config-change enable batches meta-information words
// - main rates register: gyro bits 7:4, accel 3:0, codes 0 to 10
// - gyro field also accepts code 11 for 6.5 Hz
// - timestamp at faster main rate divided by 1, 8 or 32
// - temperature rate codes: off, 1.6, 12.5, 52 Hz
// - aux register: decimation 7:6, temperature 5:4, mode 2:0, bit 3 zero
// - writing counter-clear clears sample counter, bit reads back zero
// - counter-source bit picks accel batches at 0, gyro at 1
// - 10-bit counter threshold, top bits in first counter register, sets flag
// - one threshold unit is one three-axis main-sensor sample
// - second counter register holds low byte of threshold
// - tag byte names the source of its six data bytes
// - counter, full, overrun, watermark each routable to both lines
// - counter flag clears when second status register is read
// - unread word count reported as 10 bits over two status registers
`timescale 1ns/1ns
`default_nettype none
`include "sensor_fifo_map.svh"

module sensor_batching_fifo_control (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic accel_drdy,
    input wire logic [47:0] accel_data,
    input wire logic [3:0] accel_output_rate,
    input wire logic gyro_drdy,
    input wire logic [47:0] gyro_data,
    input wire logic [3:0] gyro_output_rate,
    input wire logic temp_drdy,
    input wire logic [15:0] temp_data,
    input wire logic [31:0] timestamp,
    input wire logic mode_trigger,
    output logic int1,
    output logic int2
);

    sensor_fifo_pkg::ctl_state_t s;
    sensor_fifo_pkg::ctl_state_t n;

    logic mem_wr;
    logic [`WORD_W-1:0] mem_wdata;
    logic [`WORD_W-1:0] head_word;

    // rank of a batch or output rate code, zero when not batched
    function automatic logic [3:0] rate_rank(input logic [3:0] code, input logic slow_ok);
        if (code != 4'h0 && code <= `RATE_CODE_MAX) begin
            rate_rank = code + `RANK_SLOW;
        end else if (slow_ok && code == `RATE_CODE_SLOW) begin
            rate_rank = `RANK_SLOW;
        end else begin
            rate_rank = 4'h0;
        end
    endfunction

    // last count of the output-rate to batch-rate divider
    function automatic logic [9:0] div_last(input logic [3:0] odr_rank, input logic [3:0] bdr_rank);
        logic [3:0] d;
        d = (odr_rank > bdr_rank) ? odr_rank - bdr_rank : 4'h0;
        div_last = (10'h1 << d) - 10'h1;
    endfunction

    // tag byte with even parity over all eight bits
    function automatic logic [7:0] make_tag(input logic [4:0] sensor, input logic [1:0] cnt);
        logic [7:0] t;
        t = {sensor, cnt, 1'b0};
        t[0] = ^t[7:1];
        make_tag = t;
    endfunction

    // fill behaviour from mode selector and trigger
    function automatic sensor_fifo_pkg::fill_state_t fill_of(input logic [2:0] mode, input logic trig);
        case (mode)
            `MODE_BYPASS: fill_of = sensor_fifo_pkg::FILL_OFF;
            `MODE_STOP_FULL: fill_of = sensor_fifo_pkg::FILL_STOP;
            `MODE_RING_TO_STOP: fill_of = trig ? sensor_fifo_pkg::FILL_STOP : sensor_fifo_pkg::FILL_RING;
            `MODE_BYPASS_TO_RING: fill_of = trig ? sensor_fifo_pkg::FILL_RING : sensor_fifo_pkg::FILL_OFF;
            `MODE_RING: fill_of = sensor_fifo_pkg::FILL_RING;
            `MODE_BYPASS_TO_STOP: fill_of = trig ? sensor_fifo_pkg::FILL_STOP : sensor_fifo_pkg::FILL_OFF;
            default: fill_of = sensor_fifo_pkg::FILL_OFF;
        endcase
    endfunction

    word_store u_store (
        .mclk(mclk),
        .wr_en(mem_wr),
        .wr_addr(s.wr_ptr),
        .wr_data(mem_wdata),
        .rd_addr(s.rd_ptr),
        .rd_data(head_word)
    );

    always_comb begin
        logic [3:0] a_rank;
        logic [3:0] g_rank;
        logic a_evt;
        logic g_evt;
        logic slot;
        logic t_evt;
        logic ts_due;
        logic [4:0] ts_last;
        logic [4:0] t_last;
        logic [8:0] watermark_level;
        logic [9:0] limit;
        logic [9:0] th;
        logic wtm_flag;
        logic full_flag;
        logic [3:0] flags;
        logic pop;
        logic push;
        logic over;
        logic sel_any;
        logic [2:0] sel;
        logic [4:0] sel_tag;
        logic [47:0] sel_data;
        logic [2:0] off;
        logic [7:0] rd_byte;
        logic stat_rd;
        a_rank = 4'h0;
        g_rank = 4'h0;
        a_evt = 1'b0;
        g_evt = 1'b0;
        slot = 1'b0;
        t_evt = 1'b0;
        ts_due = 1'b0;
        ts_last = `TS_LAST_DIV1;
        t_last = `TEMP_LAST_52;
        sel_any = 1'b0;
        sel = 3'h0;
        sel_tag = 5'h00;
        sel_data = 48'h0;
        off = 3'h0;
        rd_byte = 8'h00;
        push = 1'b0;
        over = 1'b0;
        n = s;

        // programmed thresholds and flags
        watermark_level = {s.wtm_high[`BIT_WATERMARK_MSB], s.wtm_low};
        limit = s.wtm_high[`BIT_STOP_AT_WATERMARK] ? {1'b0, watermark_level} : `FIFO_DEPTH;
        th = {s.cnt_ctrl[1:0], s.cnt_th_low};
        wtm_flag = s.count >= {1'b0, watermark_level};
        full_flag = ({1'b0, s.count} + 11'h001) >= {1'b0, limit};
        flags = {s.sample_flag, full_flag, s.ovr_flag, wtm_flag};
        stat_rd = reg_re && reg_addr == `ADDR_STATUS_HIGH;
        pop = reg_re && reg_addr == `ADDR_OUT_LAST && s.count != 10'h000;

        // batch events decimated from the sensor data-ready strobes
        a_rank = rate_rank(s.main_rates[3:0], 1'b0);
        g_rank = rate_rank(s.main_rates[7:4], 1'b1);
        if (accel_drdy && a_rank != 4'h0) begin
            a_evt = s.accel_div >= div_last(rate_rank(accel_output_rate, 1'b0), a_rank);
            n.accel_div = a_evt ? 10'h000 : s.accel_div + 10'h001;
            if (a_evt) begin
                n.accel_hold = accel_data;
            end
        end
        if (gyro_drdy && g_rank != 4'h0) begin
            g_evt = s.gyro_div >= div_last(rate_rank(gyro_output_rate, 1'b1), g_rank);
            n.gyro_div = g_evt ? 10'h000 : s.gyro_div + 10'h001;
            if (g_evt) begin
                n.gyro_hold = gyro_data;
            end
        end
        slot = (g_rank > a_rank) ? g_evt : a_evt;

        // temperature decimation from its own strobe
        unique case (s.aux_rates[5:4])
            2'h1: t_last = `TEMP_LAST_1P6;
            2'h2: t_last = `TEMP_LAST_12P5;
            2'h3: t_last = `TEMP_LAST_52;
            2'h0: t_last = `TEMP_LAST_52;
        endcase
        if (temp_drdy && s.aux_rates[5:4] != 2'h0) begin
            t_evt = s.temp_div >= t_last;
            n.temp_div = t_evt ? 5'h00 : s.temp_div + 5'h01;
        end

        // timestamp decimation on the time-slot base
        unique case (s.aux_rates[7:6])
            2'h1: ts_last = `TS_LAST_DIV1;
            2'h2: ts_last = `TS_LAST_DIV8;
            2'h3: ts_last = `TS_LAST_DIV32;
            2'h0: ts_last = `TS_LAST_DIV1;
        endcase
        if (slot && s.aux_rates[7:6] != 2'h0) begin
            ts_due = s.ts_div >= ts_last;
            n.ts_div = ts_due ? 5'h00 : s.ts_div + 5'h01;
        end

        // pick the lowest-index pending word, gyro first
        for (int i = 4; i >= 0; i--) begin
            if (s.pend[i]) begin
                sel_any = 1'b1;
                sel = i[2:0];
            end
        end
        case (sel)
            3'h0: begin
                sel_tag = `TAG_GYRO;
                sel_data = s.gyro_hold;
            end
            3'h1: begin
                sel_tag = `TAG_ACCEL;
                sel_data = s.accel_hold;
            end
            3'h2: begin
                sel_tag = `TAG_TEMP;
                sel_data = {32'h0, temp_data};
            end
            3'h3: begin
                sel_tag = `TAG_TIME;
                sel_data = {16'h0, timestamp};
            end
            3'h4: begin
                sel_tag = `TAG_CFG;
                sel_data = {16'h0, s.aux_rates, s.main_rates, accel_output_rate, gyro_output_rate, 8'h00};
            end
            default: begin
                sel_tag = 5'h00;
                sel_data = 48'h0;
            end
        endcase
        mem_wdata = {sel_data, make_tag(sel_tag, s.tag_cnt)};

        // store, drop or overwrite according to fill behaviour
        n.fill = fill_of(s.aux_rates[2:0], mode_trigger);
        if (s.fill == sensor_fifo_pkg::FILL_OFF) begin
            n.wr_ptr = 9'h000;
            n.rd_ptr = 9'h000;
            n.count = 10'h000;
            n.pend = 5'h00;
            n.ovr_flag = 1'b0;
            pop = 1'b0;
        end else begin
            if (sel_any) begin
                n.pend[sel] = 1'b0;
                if (s.count < limit || pop) begin
                    push = 1'b1;
                end else if (s.fill == sensor_fifo_pkg::FILL_RING) begin
                    over = 1'b1;
                end
            end
            if (push || over) begin
                n.wr_ptr = s.wr_ptr + 9'h001;
            end
            if (pop || over) begin
                n.rd_ptr = s.rd_ptr + 9'h001;
            end
            n.count = s.count + {9'h000, push} - {9'h000, pop};
            if (pop) begin
                n.ovr_flag = 1'b0;
            end
            if (over) begin
                n.ovr_flag = 1'b1;
            end
        end
        mem_wr = push || over;

        // queue words at each time slot; ready bits wait for the next slot
        if (slot) begin
            n.tag_cnt = s.tag_cnt + 2'h1;
            n.pend[`PEND_GYRO] = n.pend[`PEND_GYRO] | g_evt | s.gyro_ready;
            n.pend[`PEND_ACCEL] = n.pend[`PEND_ACCEL] | a_evt | s.accel_ready;
            n.pend[`PEND_TEMP] = n.pend[`PEND_TEMP] | t_evt | s.temp_ready;
            n.pend[`PEND_TIME] = n.pend[`PEND_TIME] | ts_due;
            n.pend[`PEND_CFG] = n.pend[`PEND_CFG] | s.cfg_ready;
            n.gyro_ready = 1'b0;
            n.accel_ready = 1'b0;
            n.temp_ready = 1'b0;
            n.cfg_ready = 1'b0;
        end else begin
            n.gyro_ready = s.gyro_ready | g_evt;
            n.accel_ready = s.accel_ready | a_evt;
            n.temp_ready = s.temp_ready | t_evt;
        end

        // batched-sample counter
        if (reg_we && reg_addr == `ADDR_COUNTER_CTRL && reg_wdata[`BIT_COUNTER_CLEAR]) begin
            n.sample_cnt = 10'h000;
        end else if (s.cnt_ctrl[`BIT_COUNTER_SOURCE] ? g_evt : a_evt) begin
            n.sample_cnt = s.sample_cnt + 10'h001;
        end

        // status flags: a set in the clearing cycle wins
        if (stat_rd) begin
            n.sample_flag = 1'b0;
            n.ovr_latched = 1'b0;
        end
        if (over) begin
            n.ovr_latched = 1'b1;
        end
        if (n.sample_cnt != s.sample_cnt && n.sample_cnt == th) begin
            n.sample_flag = 1'b1;
        end

        // register writes
        if (reg_we) begin
            unique case (reg_addr)
                `ADDR_WATERMARK_LOW: n.wtm_low = reg_wdata;
                `ADDR_WATERMARK_HIGH: n.wtm_high = reg_wdata & `MASK_WATERMARK_HIGH;
                `ADDR_MAIN_RATES: n.main_rates = reg_wdata;
                `ADDR_AUX_RATES: n.aux_rates = reg_wdata & `MASK_AUX_RATES;
                `ADDR_COUNTER_CTRL: n.cnt_ctrl = reg_wdata & `MASK_COUNTER_CTRL;
                `ADDR_COUNTER_TH_LOW: n.cnt_th_low = reg_wdata;
                `ADDR_LINE1_ROUTE: n.line1_route = reg_wdata & `MASK_ROUTE;
                `ADDR_LINE2_ROUTE: n.line2_route = reg_wdata & `MASK_ROUTE;
                default: n.wtm_low = n.wtm_low;
            endcase
            if ((reg_addr == `ADDR_MAIN_RATES || reg_addr == `ADDR_AUX_RATES) && s.wtm_high[`BIT_CONFIG_CHANGE]) begin
                n.cfg_ready = 1'b1;
            end
        end

        // register reads
        off = 3'(reg_addr - `ADDR_OUT_TAG);
        unique case (reg_addr)
            `ADDR_WATERMARK_LOW: rd_byte = s.wtm_low;
            `ADDR_WATERMARK_HIGH: rd_byte = s.wtm_high;
            `ADDR_MAIN_RATES: rd_byte = s.main_rates;
            `ADDR_AUX_RATES: rd_byte = s.aux_rates;
            `ADDR_COUNTER_CTRL: rd_byte = s.cnt_ctrl;
            `ADDR_COUNTER_TH_LOW: rd_byte = s.cnt_th_low;
            `ADDR_LINE1_ROUTE: rd_byte = s.line1_route;
            `ADDR_LINE2_ROUTE: rd_byte = s.line2_route;
            `ADDR_STATUS_LOW: rd_byte = s.count[7:0];
            `ADDR_STATUS_HIGH: rd_byte = {wtm_flag, s.ovr_flag, full_flag, s.sample_flag,
                                          s.ovr_latched, 1'b0, s.count[9:8]};
            default: begin
                if (reg_addr >= `ADDR_OUT_TAG && reg_addr <= `ADDR_OUT_LAST && s.count != 10'h000) begin
                    rd_byte = head_word[{off, 3'h0} +: 8];
                end else begin
                    rd_byte = 8'h00;
                end
            end
        endcase
        n.rvalid = reg_re;
        if (reg_re) begin
            n.rdata = rd_byte;
        end

        // interrupt line routing
        n.line1 = |(s.line1_route[`ROUTE_MSB:`ROUTE_LSB] & flags);
        n.line2 = |(s.line2_route[`ROUTE_MSB:`ROUTE_LSB] & flags);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s <= '0;
            s.wtm_low <= `RESET_BYTE;
            s.wtm_high <= `RESET_BYTE;
            s.main_rates <= `RESET_BYTE;
            s.aux_rates <= `RESET_BYTE;
            s.cnt_ctrl <= `RESET_BYTE;
            s.cnt_th_low <= `RESET_BYTE;
            s.line1_route <= `RESET_BYTE;
            s.line2_route <= `RESET_BYTE;
            s.fill <= sensor_fifo_pkg::FILL_OFF;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign reg_rvalid = s.rvalid;
    assign int1 = s.line1;
    assign int2 = s.line2;

endmodule

`default_nettype wire

// ===== hdl/sensor_fifo_map.svh
// register map, field positions, reset values and counts of the batching fifo
`ifndef SENSOR_FIFO_MAP_SVH
`define SENSOR_FIFO_MAP_SVH

`define ADDR_WATERMARK_LOW 8'h07
`define ADDR_WATERMARK_HIGH 8'h08
`define ADDR_MAIN_RATES 8'h09
`define ADDR_AUX_RATES 8'h0a
`define ADDR_COUNTER_CTRL 8'h0b
`define ADDR_COUNTER_TH_LOW 8'h0c
`define ADDR_LINE1_ROUTE 8'h0d
`define ADDR_LINE2_ROUTE 8'h0e
`define ADDR_STATUS_LOW 8'h3a
`define ADDR_STATUS_HIGH 8'h3b
`define ADDR_OUT_TAG 8'h78
`define ADDR_OUT_LAST 8'h7e

`define MASK_WATERMARK_HIGH 8'h91
`define MASK_AUX_RATES 8'hf7
`define MASK_COUNTER_CTRL 8'h23
`define MASK_ROUTE 8'h78

`define BIT_STOP_AT_WATERMARK 7
`define BIT_CONFIG_CHANGE 4
`define BIT_WATERMARK_MSB 0
`define BIT_COUNTER_CLEAR 6
`define BIT_COUNTER_SOURCE 5
`define ROUTE_LSB 3
`define ROUTE_MSB 6

`define RESET_BYTE 8'h00

`define FIFO_DEPTH 10'h200
`define PTR_W 9
`define WORD_W 56

`define RATE_CODE_MAX 4'ha
`define RATE_CODE_SLOW 4'hb
`define RANK_SLOW 4'h1

`define TS_LAST_DIV1 5'h00
`define TS_LAST_DIV8 5'h07
`define TS_LAST_DIV32 5'h1f
`define TEMP_LAST_1P6 5'h1f
`define TEMP_LAST_12P5 5'h03
`define TEMP_LAST_52 5'h00

`define TAG_GYRO 5'h01
`define TAG_ACCEL 5'h02
`define TAG_TEMP 5'h03
`define TAG_TIME 5'h04
`define TAG_CFG 5'h05

`define PEND_GYRO 0
`define PEND_ACCEL 1
`define PEND_TEMP 2
`define PEND_TIME 3
`define PEND_CFG 4

`define MODE_BYPASS 3'h0
`define MODE_STOP_FULL 3'h1
`define MODE_RING_TO_STOP 3'h3
`define MODE_BYPASS_TO_RING 3'h4
`define MODE_RING 3'h6
`define MODE_BYPASS_TO_STOP 3'h7

`endif

// ===== hdl/sensor_fifo_pkg.sv
// types of the batching fifo control
package sensor_fifo_pkg;

    typedef enum logic [2:0] {
        FILL_OFF = 3'h1,
        FILL_STOP = 3'h2,
        FILL_RING = 3'h4
    } fill_state_t;

    typedef struct packed {
        logic [7:0] wtm_low;
        logic [7:0] wtm_high;
        logic [7:0] main_rates;
        logic [7:0] aux_rates;
        logic [7:0] cnt_ctrl;
        logic [7:0] cnt_th_low;
        logic [7:0] line1_route;
        logic [7:0] line2_route;
        fill_state_t fill;
        logic [8:0] wr_ptr;
        logic [8:0] rd_ptr;
        logic [9:0] count;
        logic [9:0] accel_div;
        logic [9:0] gyro_div;
        logic [4:0] temp_div;
        logic [4:0] ts_div;
        logic [1:0] tag_cnt;
        logic accel_ready;
        logic gyro_ready;
        logic temp_ready;
        logic cfg_ready;
        logic [4:0] pend;
        logic [47:0] accel_hold;
        logic [47:0] gyro_hold;
        logic ovr_flag;
        logic ovr_latched;
        logic sample_flag;
        logic [9:0] sample_cnt;
        logic [7:0] rdata;
        logic rvalid;
        logic line1;
        logic line2;
    } ctl_state_t;

endpackage

// ===== hdl/word_store.sv
// storage array of the fifo words
`timescale 1ns/1ns
`default_nettype none
`include "sensor_fifo_map.svh"

module word_store (
    input wire logic mclk,
    input wire logic wr_en,
    input wire logic [`PTR_W-1:0] wr_addr,
    input wire logic [`WORD_W-1:0] wr_data,
    input wire logic [`PTR_W-1:0] rd_addr,
    output logic [`WORD_W-1:0] rd_data
);

    logic [`WORD_W-1:0] mem [0:(1<<`PTR_W)-1];

    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];

endmodule

`default_nettype wire

// ===== sim/fifo_ctl_monitor.sv
// concurrent checks on the register port of the batching fifo control
`timescale 1ns/1ns
`default_nettype none
module fifo_ctl_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    read_answer_a: assert property (reg_re |=> reg_rvalid)
        else $error("read strobe without answer");
    no_stray_answer_a: assert property (!reg_re |=> !reg_rvalid)
        else $error("answer without read strobe");
    data_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    watermark_readback_a: assert property (reg_we && reg_addr == 8'h07 ##1 !reg_we ##1
        reg_re && reg_addr == 8'h07 |=> reg_rdata == $past(reg_wdata, 3))
        else $error("watermark low byte lost");
    ctrl_reserved_a: assert property (reg_re && reg_addr == 8'h08 |=> (reg_rdata & 8'h6e) == 8'h00)
        else $error("reserved watermark control bits set");
    aux_bit3_zero_a: assert property (reg_re && reg_addr == 8'h0a |=> reg_rdata[3] == 1'b0)
        else $error("aux register bit 3 not zero");
    clear_bit_zero_a: assert property (reg_re && reg_addr == 8'h0b |=> (reg_rdata & 8'hdc) == 8'h00)
        else $error("counter control reads back clear or reserved bits");
    count_bound_a: assert property (reg_re && reg_addr == 8'h3b |=> reg_rdata[1:0] != 2'b11 && !reg_rdata[2])
        else $error("unread count above depth");
endmodule
bind sensor_batching_fifo_control fifo_ctl_monitor mon_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
`default_nettype wire

// ===== sim/host_model.sv
// host register master for the batching fifo control
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    output logic reg_re,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
        reg_re = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge mclk);
        reg_we <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        reg_addr <= ~a;
        @(negedge mclk);
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
endmodule
`default_nettype wire

// ===== sim/sensor_batching_fifo_control_tb_top.sv
// self-checking bench of the batching fifo control
`timescale 1ns/1ns
`default_nettype none
module sensor_batching_fifo_control_tb_top;
    logic mclk;
    logic rst_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, s1, s2;
    logic reg_we, reg_re, reg_rvalid, int1, int2;
    logic accel_drdy, gyro_drdy, temp_drdy, mode_trigger;
    logic [47:0] accel_data, gyro_data;
    logic [3:0] accel_output_rate, gyro_output_rate;
    logic [15:0] temp_data;
    logic [31:0] timestamp = 32'h0;
    logic [47:0] words[$];
    logic [7:0] addrs[8] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
    int errors = 0;
    int tests_run = 0;

    sensor_batching_fifo_control dut_u (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .accel_drdy(accel_drdy), .accel_data(accel_data), .accel_output_rate(accel_output_rate),
        .gyro_drdy(gyro_drdy), .gyro_data(gyro_data), .gyro_output_rate(gyro_output_rate),
        .temp_drdy(temp_drdy), .temp_data(temp_data), .timestamp(timestamp),
        .mode_trigger(mode_trigger), .int1(int1), .int2(int2));
    host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    always @(posedge mclk) timestamp <= timestamp + 32'h1;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    function automatic logic [7:0] rd_mask(input logic [7:0] a);
        case (a)
            8'h08: return 8'h91;
            8'h0a: return 8'hf7;
            8'h0b: return 8'h23;
            8'h0d, 8'h0e: return 8'h78;
            default: return 8'hff;
        endcase
    endfunction

    task automatic pulse(input int n, input bit keep, input bit gy = 1'b0);
        repeat (n) begin
            @(posedge mclk);
            accel_drdy <= 1'b1;
            gyro_drdy <= 1'b1;
            temp_drdy <= 1'b1;
            accel_data <= 48'({$urandom(), $urandom()});
            gyro_data <= 48'({$urandom(), $urandom()});
            @(posedge mclk);
            accel_drdy <= 1'b0;
            gyro_drdy <= 1'b0;
            temp_drdy <= 1'b0;
            if (gy) words.push_back(gyro_data);
            if (keep) words.push_back(accel_data);
            repeat (4) @(posedge mclk);
        end
    endtask

    task automatic count_is(input logic [9:0] n);
        host_u.rd(8'h3a, s1);
        host_u.rd(8'h3b, s2);
        check(16'({s2[1:0], s1}), 16'(n));
    endtask

    task automatic pop_word(input logic [4:0] src, input bit chk);
        logic [47:0] exp;
        exp = chk ? words.pop_front() : 48'h0;
        host_u.rd(8'h78, v);
        check(16'(v[7:3]), 16'(src));
        check(16'(^v), 16'h0000);
        for (int i = 0; i < 6; i++) begin
            host_u.rd(8'h79 + 8'(i), v);
            if (chk) check(16'(v), 16'(exp[8*i +: 8]));
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        give_verdict();
    end

    initial begin
        rst_n = 1'b0;
        accel_drdy = 1'b0;
        gyro_drdy = 1'b0;
        temp_drdy = 1'b0;
        mode_trigger = 1'b0;
        accel_data = 48'h0;
        gyro_data = 48'h0;
        temp_data = 16'h0;
        accel_output_rate = 4'h4;
        gyro_output_rate = 4'hb;
        void'($urandom(54));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (addrs[i]) begin
            host_u.rd(addrs[i], v);
            check(16'(v), 16'h0000);
        end
        foreach (addrs[i]) begin
            s1 = 8'($urandom()) & (addrs[i] == 8'h08 ? 8'h81 : 8'hff);
            host_u.wr(addrs[i], s1);
            host_u.rd(addrs[i], v);
            check(16'(v), 16'(s1 & rd_mask(addrs[i])));
        end
        host_u.wr(8'h09, 8'hb0);
        host_u.rd(8'h09, v);
        check(16'(v), 16'h00b0);
        host_u.rd(8'h20, v);
        check(16'(v), 16'h0000);
        $display("test registers done");
        host_u.wr(8'h0d, 8'h00);
        host_u.wr(8'h0e, 8'h00);
        host_u.wr(8'h08, 8'h00);
        host_u.wr(8'h0a, 8'h00);
        host_u.wr(8'h0b, 8'h40);
        host_u.wr(8'h0c, 8'h02);
        host_u.wr(8'h07, 8'h03);
        host_u.wr(8'h0a, 8'h01);
        host_u.wr(8'h09, 8'h04);
        pulse(4, 1'b1);
        count_is(10'd4);
        check(16'(s2[7]), 16'h0001);
        check(16'(s2[4]), 16'h0001);
        host_u.rd(8'h3b, v);
        check(16'(v[4]), 16'h0000);
        pop_word(5'h02, 1'b1);
        count_is(10'd3);
        check(16'(s2[7]), 16'h0001);
        host_u.wr(8'h08, 8'h80);
        pulse(2, 1'b0);
        count_is(10'd3);
        repeat (3) pop_word(5'h02, 1'b1);
        count_is(10'd0);
        check(16'(s2[7]), 16'h0000);
        $display("test fill and watermark done");
        host_u.wr(8'h0b, 8'h60);
        pulse(3, 1'b1);
        host_u.rd(8'h3b, v);
        check(16'(v[4]), 16'h0000);
        host_u.wr(8'h0d, 8'h08);
        repeat (3) @(negedge mclk);
        check(16'({int1, int2}), 16'h0002);
        host_u.wr(8'h0e, 8'h08);
        host_u.wr(8'h0d, 8'h00);
        repeat (3) @(negedge mclk);
        check(16'({int1, int2}), 16'h0001);
        host_u.wr(8'h0e, 8'h00);
        repeat (3) pop_word(5'h02, 1'b1);
        $display("test counter and lines done");
        host_u.wr(8'h08, 8'h10);
        host_u.wr(8'h0c, 8'h01);
        host_u.wr(8'h09, 8'hb4);
        host_u.wr(8'h0a, 8'h71);
        pulse(1, 1'b1, 1'b1);
        count_is(10'd5);
        check(16'(s2[4]), 16'h0001);
        pop_word(5'h01, 1'b1);
        pop_word(5'h02, 1'b1);
        pop_word(5'h03, 1'b0);
        pop_word(5'h04, 1'b0);
        pop_word(5'h05, 1'b0);
        count_is(10'd0);
        $display("test auxiliary words done");
        host_u.wr(8'h08, 8'h80);
        host_u.wr(8'h07, 8'h02);
        host_u.wr(8'h0d, 8'h10);
        host_u.wr(8'h0e, 8'h20);
        host_u.wr(8'h0a, 8'h06);
        pulse(2, 1'b0);
        @(negedge mclk);
        check(16'({int1, int2}), 16'h0003);
        count_is(10'd2);
        check(16'(s2), 16'h00e8);
        host_u.rd(8'h3b, v);
        check(16'(v), 16'h00e0);
        pop_word(5'h01, 1'b0);
        pop_word(5'h02, 1'b0);
        count_is(10'd0);
        check(16'(s2), 16'h0000);
        host_u.wr(8'h0a, 8'h04);
        pulse(1, 1'b0);
        count_is(10'd0);
        @(posedge mclk);
        mode_trigger <= 1'b1;
        pulse(1, 1'b0);
        count_is(10'd2);
        $display("test overrun and modes done");
        give_verdict();
    end
endmodule
`default_nettype wire
